// ===== design/dmx_exec.sv
`timescale 1ns/1ns
// Overview of operation
// - Bank literal loads 5-bit immediate into bank select, no flags touched.
// - Page literal loads 7-bit immediate into program counter high latch, no flags.
// - Store to file writes work register to file address 0..127, one cycle.
// - Pre modes address pointer plus or minus one, and write it back.
// - Post modes use old pointer, then step it; offset form keeps pointer.
// - Offset form adds signed offset -32..31 to pointer for the address.
// - Pointers are 16 bits and wrap modulo 65536 on step.
// - Pointer steps and indirect stores leave every status flag untouched.
// - Option load copies work register into timer option register, no flags.
// - Software reset pulses a whole-device reset request and the reset instruction flag clear.
module dmx_exec
  import dmx_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Decoded instruction
  input wire logic exec_valid_i,
  input wire dmx_op_t exec_op_i,
  input wire logic [7:0] literal_i,
  input wire logic [DMX_FILE_W-1:0] file_addr_i,
  input wire logic pointer_index_i,
  input wire logic [1:0] pointer_mode_code_i,
  input wire logic offset_mode_i,
  input wire logic [DMX_OFS_W-1:0] offset_i,
  // Data memory write port
  output logic mem_write_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_data_o,
  // Architectural state
  output logic [7:0] work_o,
  output logic [DMX_BANK_W-1:0] bank_select_register_o,
  output logic [DMX_PAGE_W-1:0] program_counter_high_latch_o,
  output logic [DMX_PTR_W-1:0] file_select_pointer0_o,
  output logic [DMX_PTR_W-1:0] file_select_pointer1_o,
  output logic [7:0] option_o,
  output logic status_write_o,
  // Software reset
  output logic device_reset_req_o,
  output logic reset_instruction_flag_clear_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Plain 16-bit add; the carry out is dropped so the pointer wraps
  function automatic logic [15:0] ptr_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0];
  endfunction : ptr_add

  // Plain 16-bit subtract; the borrow is dropped so zero wraps to the top
  function automatic logic [15:0] ptr_sub(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] d;
    d = {1'b0, a} - {1'b0, b};
    return d[15:0];
  endfunction : ptr_sub

  // Sign extension of the relative offset to pointer width
  function automatic logic [15:0] offset_ext(input logic [DMX_OFS_W-1:0] k);
    return {{(DMX_PTR_W - DMX_OFS_W){k[DMX_OFS_W-1]}}, k};
  endfunction : offset_ext

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] work, next_work;
  logic [4:0] bank, next_bank;
  logic [6:0] page, next_page;
  logic [15:0] ptr0, next_ptr0;
  logic [15:0] ptr1, next_ptr1;
  logic [7:0] option, next_option;
  logic mem_write, next_mem_write;
  logic [15:0] mem_addr, next_mem_addr;
  logic [7:0] mem_data, next_mem_data;
  logic rst_req, next_rst_req;

  // ---------------------------------------------------------------
  // Shared decode
  // ---------------------------------------------------------------
  logic [15:0] sel_ptr;
  logic [15:0] stepped_ptr;
  logic [15:0] offset_addr;
  logic do_file_store;
  logic do_indirect;
  logic step_ptr;

  // One pointer path feeds both the write address and the update
  assign sel_ptr = pointer_index_i ? ptr1 : ptr0;
  assign stepped_ptr = pointer_mode_code_i[0] ? ptr_sub(sel_ptr, DMX_PTR_ONE)
                                              : ptr_add(sel_ptr, DMX_PTR_ONE);
  assign offset_addr = ptr_add(sel_ptr, offset_ext(offset_i));
  assign do_file_store = exec_valid_i && (exec_op_i == DMX_OP_STORE_WORK_TO_FILE);
  assign do_indirect = exec_valid_i && (exec_op_i == DMX_OP_STORE_WORK_INDIRECT);
  // Offset form keeps the pointer whatever the mode code says
  assign step_ptr = do_indirect && !offset_mode_i;

  // ---------------------------------------------------------------
  // Core registers
  // ---------------------------------------------------------------
  // Each register moves only on its own instruction; none writes a flag
  always_comb begin
    next_work = work;
    next_bank = bank;
    next_page = page;
    next_option = option;
    if (exec_valid_i) begin
      unique case (exec_op_i)
        DMX_OP_NO_OPERATION: begin
          next_work = work;
        end
        DMX_OP_LOAD_BANK_LITERAL: begin
          next_bank = literal_i[DMX_BANK_W-1:0];
        end
        DMX_OP_LOAD_PAGE_LITERAL: begin
          next_page = literal_i[DMX_PAGE_W-1:0];
        end
        DMX_OP_LOAD_WORK_LITERAL: begin
          next_work = literal_i;
        end
        DMX_OP_LOAD_OPTION: begin
          next_option = work;
        end
        // Stores and the reset request leave these alone
        DMX_OP_STORE_WORK_TO_FILE, DMX_OP_STORE_WORK_INDIRECT, DMX_OP_SOFTWARE_RESET: begin
          next_work = work;
        end
      endcase
    end
  end

  // Registered on every edge; reset values come from the package
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      work <= DMX_WORK_RST;
      bank <= DMX_BANK_RST;
      page <= DMX_PAGE_RST;
      option <= DMX_OPTION_RST;
    end else begin
      work <= next_work;
      bank <= next_bank;
      page <= next_page;
      option <= next_option;
    end
  end

  // ---------------------------------------------------------------
  // Pointers
  // ---------------------------------------------------------------
  // Only the stepping forms write back; a pointer never saturates
  always_comb begin
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    if (step_ptr && pointer_index_i) begin
      next_ptr1 = stepped_ptr;
    end else if (step_ptr) begin
      next_ptr0 = stepped_ptr;
    end
  end

  // Pointer registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ptr0 <= DMX_PTR_RST;
      ptr1 <= DMX_PTR_RST;
    end else begin
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
    end
  end

  // ---------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------
  // Strobe lasts one cycle; address and data hold until the next store
  // Data is the work register before any same-edge update
  always_comb begin
    next_mem_write = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_data = mem_data;
    if (do_file_store) begin
      next_mem_write = 1'b1;
      next_mem_addr = {9'h000, file_addr_i};
      next_mem_data = work;
    end else if (do_indirect) begin
      next_mem_write = 1'b1;
      next_mem_data = work;
      if (offset_mode_i) begin
        next_mem_addr = offset_addr;
      end else if (pointer_mode_code_i[1]) begin
        next_mem_addr = sel_ptr;
      end else begin
        next_mem_addr = stepped_ptr;
      end
    end
  end

  // Write port registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mem_write <= 1'b0;
      mem_addr <= DMX_PTR_RST;
      mem_data <= DMX_WORK_RST;
    end else begin
      mem_write <= next_mem_write;
      mem_addr <= next_mem_addr;
      mem_data <= next_mem_data;
    end
  end

  // ---------------------------------------------------------------
  // Reset request
  // ---------------------------------------------------------------
  // A one-cycle pulse; the system is expected to loop it into reset_i
  // Back-to-back reset instructions would stretch it, which is harmless
  always_comb begin
    next_rst_req = exec_valid_i && (exec_op_i == DMX_OP_SOFTWARE_RESET);
  end

  // Reset request register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rst_req <= 1'b0;
    end else begin
      rst_req <= next_rst_req;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The reset request loops back through the system reset, which
  // then clears it; flag clear pulses with it
  assign work_o = work;
  assign bank_select_register_o = bank;
  assign program_counter_high_latch_o = page;
  assign file_select_pointer0_o = ptr0;
  assign file_select_pointer1_o = ptr1;
  assign option_o = option;
  assign mem_write_o = mem_write;
  assign mem_addr_o = mem_addr;
  assign mem_data_o = mem_data;
  assign status_write_o = 1'b0;
  assign device_reset_req_o = rst_req;
  assign reset_instruction_flag_clear_o = rst_req;

endmodule : dmx_exec

// ===== design/dmx_pkg.sv
package dmx_pkg;

  // ---------------------------------------------------------------
  // Instruction selection
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DMX_OP_NO_OPERATION,
    DMX_OP_LOAD_BANK_LITERAL,
    DMX_OP_LOAD_PAGE_LITERAL,
    DMX_OP_LOAD_WORK_LITERAL,
    DMX_OP_STORE_WORK_TO_FILE,
    DMX_OP_STORE_WORK_INDIRECT,
    DMX_OP_LOAD_OPTION,
    DMX_OP_SOFTWARE_RESET
  } dmx_op_t;

  // ---------------------------------------------------------------
  // Pointer mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DMX_MODE_PRE_INC = 2'h0;
  localparam logic [1:0] DMX_MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] DMX_MODE_POST_INC = 2'h2;
  localparam logic [1:0] DMX_MODE_POST_DEC = 2'h3;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int DMX_BANK_W = 5;
  localparam int DMX_PAGE_W = 7;
  localparam int DMX_FILE_W = 7;
  localparam int DMX_PTR_W = 16;
  localparam int DMX_OFS_W = 6;
  localparam logic [4:0] DMX_BANK_RST = 5'h00;
  localparam logic [6:0] DMX_PAGE_RST = 7'h00;
  localparam logic [7:0] DMX_WORK_RST = 8'h00;
  localparam logic [7:0] DMX_OPTION_RST = 8'hFF;
  localparam logic [15:0] DMX_PTR_RST = 16'h0000;
  localparam logic [15:0] DMX_PTR_ONE = 16'h0001;

endpackage : dmx_pkg

// ===== bench/dmx_exec_sva.sv
`timescale 1ns/1ns
module dmx_exec_sva
  import dmx_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Decoded instruction
  input wire logic exec_valid_i,
  input wire dmx_op_t exec_op_i,
  input wire logic [7:0] literal_i,
  input wire logic [6:0] file_addr_i,
  input wire logic pointer_index_i,
  input wire logic [1:0] pointer_mode_code_i,
  input wire logic offset_mode_i,
  input wire logic [5:0] offset_i,
  // Design outputs
  input wire logic mem_write_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_data_o,
  input wire logic [7:0] work_o,
  input wire logic [4:0] bank_select_register_o,
  input wire logic [6:0] program_counter_high_latch_o,
  input wire logic [15:0] file_select_pointer0_o,
  input wire logic [15:0] file_select_pointer1_o,
  input wire logic [7:0] option_o,
  input wire logic status_write_o,
  input wire logic device_reset_req_o,
  input wire logic reset_instruction_flag_clear_o
);
  // One strobe per opcode, bit index is the opcode value
  logic [7:0] hit;
  always_comb for (int i = 0; i < 8; i++) hit[i] = exec_valid_i && exec_op_i == dmx_op_t'(i);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  bank_load_a: assert property (hit[1] |=> bank_select_register_o == $past(literal_i[4:0]))
    else $error("bank");
  page_load_a: assert property (hit[2] |=> program_counter_high_latch_o == $past(literal_i[6:0]))
    else $error("page");
  file_store_a: assert property (hit[4] |=> mem_write_o && mem_addr_o == {9'h000, $past(file_addr_i)}
    && mem_data_o == $past(work_o)) else $error("file store");
  post_step_a: assert property (hit[5] && !offset_mode_i && !pointer_index_i && pointer_mode_code_i == 2'h2
    |=> mem_addr_o == $past(file_select_pointer0_o)
    && file_select_pointer0_o == $past(file_select_pointer0_o) + 16'h0001) else $error("post step");
  pre_step_a: assert property (hit[5] && !offset_mode_i && pointer_index_i && pointer_mode_code_i == 2'h1
    |=> mem_addr_o == $past(file_select_pointer1_o) - 16'h0001
    && file_select_pointer1_o == mem_addr_o) else $error("pre step");
  offset_addr_a: assert property (hit[5] && offset_mode_i
    |=> mem_addr_o == $past(pointer_index_i ? file_select_pointer1_o : file_select_pointer0_o)
    + {{10{$past(offset_i[5])}}, $past(offset_i)}
    && $stable(file_select_pointer0_o) && $stable(file_select_pointer1_o)) else $error("offset store");
  flags_quiet_a: assert property (hit[5] |=> mem_write_o && !status_write_o
    && mem_data_o == $past(work_o)) else $error("indirect store");
  option_load_a: assert property (hit[6] |=> option_o == $past(work_o))
    else $error("option");
  sw_reset_a: assert property (hit[7] |=> device_reset_req_o && reset_instruction_flag_clear_o ##1 !device_reset_req_o)
    else $error("soft reset");
  work_load_a: assert property (hit[3] |=> work_o == $past(literal_i))
    else $error("work");
  nop_quiet_a: assert property (hit[0] |=> !mem_write_o && $stable(work_o))
    else $error("nop");
  cover property (hit[5] && offset_mode_i);
  cover property (hit[5] ##1 hit[5]);
  cover property (hit[7]);
  cover property (hit[5] && pointer_index_i && pointer_mode_code_i == 2'h1 && file_select_pointer1_o == 16'h0000);
endmodule : dmx_exec_sva
bind dmx_exec dmx_exec_sva i_sva (.*);

// ===== bench/test_dmx_exec.sv
`timescale 1ns/1ns
module test_dmx_exec
  import dmx_pkg::*;
;
  logic clock_i, reset_i, exec_valid_i, pointer_index_i, offset_mode_i, mem_write_o, status_write_o;
  logic device_reset_req_o, reset_instruction_flag_clear_o;
  dmx_op_t exec_op_i;
  logic [7:0] literal_i, mem_data_o, work_o, option_o;
  logic [6:0] file_addr_i, program_counter_high_latch_o;
  logic [5:0] offset_i;
  logic [4:0] bank_select_register_o;
  logic [1:0] pointer_mode_code_i;
  logic [15:0] mem_addr_o, file_select_pointer0_o, file_select_pointer1_o, nx, p [2] = '{16'h0000, 16'h0000};
  int n_errors = 0;
  int checks = 0;
  dmx_exec i_dut (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .exec_valid_i(exec_valid_i),
    .exec_op_i(exec_op_i),
    .literal_i(literal_i),
    .file_addr_i(file_addr_i),
    .pointer_index_i(pointer_index_i),
    .pointer_mode_code_i(pointer_mode_code_i),
    .offset_mode_i(offset_mode_i),
    .offset_i(offset_i),
    .mem_write_o(mem_write_o),
    .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o),
    .work_o(work_o),
    .bank_select_register_o(bank_select_register_o),
    .program_counter_high_latch_o(program_counter_high_latch_o),
    .file_select_pointer0_o(file_select_pointer0_o),
    .file_select_pointer1_o(file_select_pointer1_o),
    .option_o(option_o),
    .status_write_o(status_write_o),
    .device_reset_req_o(device_reset_req_o),
    .reset_instruction_flag_clear_o(reset_instruction_flag_clear_o)
  );
  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // Drive 5 ns after the edge so sampling never races
  task go(input logic v, input dmx_op_t o);
    exec_valid_i = v;
    exec_op_i = o;
    @(posedge clock_i);
    #5;
  endtask : go
  task report_and_stop;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Literal loads, file store and idle, all back to back
  task t_lit;
    literal_i = 8'hEF;
    file_addr_i = 7'h7F;
    go(1'h1, DMX_OP_LOAD_BANK_LITERAL);
    chk(bank_select_register_o, 16'h000F);
    go(1'h1, DMX_OP_LOAD_PAGE_LITERAL);
    chk(program_counter_high_latch_o, 16'h006F);
    go(1'h1, DMX_OP_LOAD_WORK_LITERAL);
    chk(work_o, 16'h00EF);
    go(1'h1, DMX_OP_LOAD_OPTION);
    chk(option_o, 16'h00EF);
    go(1'h1, DMX_OP_STORE_WORK_TO_FILE);
    chk({mem_write_o, mem_data_o, mem_addr_o[6:0]}, 16'hF7FF);
    go(1'h1, DMX_OP_NO_OPERATION);
    chk({mem_write_o, work_o}, 16'h00EF);
    go(1'h0, DMX_OP_STORE_WORK_TO_FILE);
    chk({mem_write_o, option_o}, 16'h00EF);
    $display("done literals");
  endtask : t_lit
  // Modes 3..0 per pointer; start at zero so both wraps occur
  task t_ind;
    for (int i = 0; i < 8; i++) begin
      pointer_index_i = i[2];
      pointer_mode_code_i = 2'h3 - i[1:0];
      go(1'h1, DMX_OP_STORE_WORK_INDIRECT);
      nx = pointer_mode_code_i[0] ? p[i[2]] - 16'h0001 : p[i[2]] + 16'h0001;
      chk(mem_addr_o, pointer_mode_code_i[1] ? p[i[2]] : nx);
      p[i[2]] = nx;
      chk(file_select_pointer0_o, p[0]);
      chk(file_select_pointer1_o, p[1]);
      chk({mem_write_o, status_write_o, mem_data_o}, 16'h02EF);
    end
    offset_mode_i = 1'h1;
    offset_i = 6'h20;
    go(1'h1, DMX_OP_STORE_WORK_INDIRECT);
    chk(mem_addr_o, p[1] - 16'h0020);
    offset_i = 6'h1F;
    go(1'h1, DMX_OP_STORE_WORK_INDIRECT);
    chk(mem_addr_o, p[1] + 16'h001F);
    chk(file_select_pointer1_o, p[1]);
    go(1'h0, DMX_OP_NO_OPERATION);
    $display("done indirect");
  endtask : t_ind
  // Request is a pulse; the system must feed it back to reset
  task t_rst;
    go(1'h1, DMX_OP_SOFTWARE_RESET);
    chk({device_reset_req_o, reset_instruction_flag_clear_o}, 16'h0003);
    go(1'h0, DMX_OP_NO_OPERATION);
    chk({device_reset_req_o, reset_instruction_flag_clear_o}, 16'h0000);
    go(1'h0, DMX_OP_NO_OPERATION);
    reset_i = 1'h1;
    go(1'h0, DMX_OP_NO_OPERATION);
    reset_i = 1'h0;
    chk({option_o, work_o}, 16'hFF00);
    chk({bank_select_register_o, program_counter_high_latch_o}, 16'h0000);
    $display("done reset");
  endtask : t_rst
  initial begin
    reset_i = 1'h1;
    {exec_valid_i, literal_i, file_addr_i, pointer_index_i, pointer_mode_code_i, offset_mode_i, offset_i} = '0;
    exec_op_i = DMX_OP_NO_OPERATION;
    repeat (12) @(posedge clock_i);
    #5;
    reset_i = 1'h0;
    t_lit;
    t_ind;
    t_rst;
    report_and_stop;
  end
  // About 35 cycles of tests; a hang is cut at 500 cycles
  initial begin
    #25000;
    n_errors++;
    report_and_stop;
  end
endmodule : test_dmx_exec
